// ### rtl/rtc_ctrl.sv
// Control, oscillator and snapshot registers of the RTC
`timescale 1ns/1ns
module rtc_ctrl
  import rtc_osc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Oscillator and alarm auto-reset
  input wire logic osc_amplitude_ok,
  output logic osc_gain_ctrl_enable,
  output logic osc_mode_select,
  output logic osc_bias_double,
  output logic alarm_auto_reset,
  // Interrupt
  output logic irq
);
  timer_if tmr();
  rtc_timer_core u_core (.ref_clk(ref_clk), .rst_n(rst_n), .tmr(tmr));

  typedef struct packed {
    logic [3:0][7:0] snap;
    logic [7:0] osc;
    logic alarm_flag;
    logic auto_rst;
    op_t op;
    logic [1:0] cnt;
    logic load;
    logic amp_s;
    logic [2:0] stat;
    logic [2:0] en;
    logic [7:0] rdata;
    logic irq;
  } st_t;
  st_t q, d;
  logic [1:0] idx;
  logic [2:0] ev;

  always_comb begin
    d = q;
    ev = '0;
    idx = addr[1:0];
    d.load = 1'b0;
    d.amp_s = osc_amplitude_ok;
    d.rdata = 8'h00;
    // Alarm flag is sticky; auto-reset drops it once the compare ends
    if (tmr.alarm) begin
      d.alarm_flag = 1'b1;
      ev[IRQ_ALARM] = 1'b1;
    end else if (q.auto_rst) begin
      d.alarm_flag = 1'b0;
    end
    // Load or snapshot runs OP_LAT cycles, then its trigger clears
    if (q.op != OP_IDLE) begin
      if (q.cnt == 2'(OP_LAT - 1)) begin
        d.op = OP_IDLE;
        d.cnt = '0;
        if (q.op == OP_LOAD) begin
          d.load = 1'b1;
          ev[IRQ_LOAD] = 1'b1;
        end else begin
          d.snap = tmr.count;
          ev[IRQ_SNAP] = 1'b1;
        end
      end else begin
        d.cnt = q.cnt + 2'd1;
      end
    end
    // Register writes; a new trigger is refused while one is busy
    if (wr) begin
      if (addr <= ADDR_SNAP3) begin
        d.snap[idx] = wdata;
      end else if (addr == ADDR_CTRL) begin
        d.auto_rst = wdata[BIT_ALARM];
        if (q.op == OP_IDLE && wdata[BIT_LOAD]) begin
          d.op = OP_LOAD;
        end else if (q.op == OP_IDLE && wdata[BIT_SNAP]) begin
          d.op = OP_SNAP;
        end
      end else if (addr == ADDR_OSC) begin
        d.osc = wdata & OSC_WMASK;
      end else if (addr == ADDR_IRQ_EN) begin
        d.en = wdata[2:0];
      end else if (addr == ADDR_IRQ_CLR) begin
        d.stat = q.stat & ~wdata[2:0];
      end
    end
    // Events are applied after the clear so that set wins
    d.stat = d.stat | ev;
    // Read data are registered and zero outside the cycle after a read
    if (rd) begin
      if (addr <= ADDR_SNAP3) begin
        d.rdata = q.snap[idx];
      end else if (addr == ADDR_CTRL) begin
        d.rdata[BIT_ALARM] = q.alarm_flag;
        d.rdata[BIT_LOAD] = (q.op == OP_LOAD);
        d.rdata[BIT_SNAP] = (q.op == OP_SNAP);
      end else if (addr == ADDR_OSC) begin
        d.rdata = q.osc;
        d.rdata[BIT_VALID] = q.amp_s;
      end else if (addr == ADDR_IRQ_STAT) begin
        d.rdata = {5'h00, q.stat};
      end else if (addr == ADDR_IRQ_EN) begin
        d.rdata = {5'h00, q.en};
      end
    end
    d.irq = |(d.stat & d.en);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      q <= '0;
      q.osc <= OSC_RESET;
    end else begin
      q <= d;
    end
  end

  assign tmr.load = q.load;
  assign tmr.load_val = q.snap;
  assign rdata = q.rdata;
  assign osc_gain_ctrl_enable = q.osc[BIT_GAIN];
  assign osc_mode_select = q.osc[BIT_MODE];
  assign osc_bias_double = q.osc[BIT_BIAS];
  assign alarm_auto_reset = q.auto_rst;
  assign irq = q.irq;

  property p_load_clears;
    @(posedge ref_clk) disable iff (!rst_n)
      (q.op == OP_IDLE && wr && addr == ADDR_CTRL && wdata[BIT_LOAD])
      |=> (q.op == OP_LOAD) ##2 (q.op == OP_IDLE && tmr.load);
  endproperty
  a_load_clears: assert property (p_load_clears)
    else $error("load trigger did not complete in time");
  property p_snap_clears;
    @(posedge ref_clk) disable iff (!rst_n)
      (q.op == OP_IDLE && wr && addr == ADDR_CTRL && !wdata[BIT_LOAD]
       && wdata[BIT_SNAP]) |=> (q.op == OP_SNAP) ##2 (q.op == OP_IDLE);
  endproperty
  a_snap_clears: assert property (p_snap_clears)
    else $error("snapshot trigger did not complete in time");
  property p_snap_val;
    @(posedge ref_clk) disable iff (!rst_n)
      (q.op == OP_SNAP && q.cnt == 2'(OP_LAT - 1))
      |=> (q.snap == $past(tmr.count));
  endproperty
  a_snap_val: assert property (p_snap_val)
    else $error("snapshot bytes do not hold timer value");
  property p_load_val;
    @(posedge ref_clk) disable iff (!rst_n)
      tmr.load |=> (tmr.count == $past(q.snap));
  endproperty
  a_load_val: assert property (p_load_val)
    else $error("timer not loaded from snapshot bytes");
  property p_alarm_read;
    @(posedge ref_clk) disable iff (!rst_n)
      (rd && addr == ADDR_CTRL) |=> (rdata[BIT_ALARM] == $past(q.alarm_flag));
  endproperty
  a_alarm_read: assert property (p_alarm_read)
    else $error("alarm flag read wrong");
  property p_auto_write;
    @(posedge ref_clk) disable iff (!rst_n)
      (wr && addr == ADDR_CTRL) |=> (alarm_auto_reset == $past(wdata[BIT_ALARM]));
  endproperty
  a_auto_write: assert property (p_auto_write)
    else $error("auto reset not written");
  property p_osc_write;
    @(posedge ref_clk) disable iff (!rst_n)
      (wr && addr == ADDR_OSC) |=> (osc_gain_ctrl_enable == $past(wdata[7])
      && osc_mode_select == $past(wdata[6])
      && osc_bias_double == $past(wdata[5]));
  endproperty
  a_osc_write: assert property (p_osc_write)
    else $error("oscillator control bits not stored");
  property p_osc_read;
    @(posedge ref_clk) disable iff (!rst_n)
      (rd && addr == ADDR_OSC) |=> (rdata[3:0] == 4'h0
      && rdata[BIT_VALID] == $past(q.amp_s));
  endproperty
  a_osc_read: assert property (p_osc_read)
    else $error("oscillator status read wrong");
  // Oscillator bits change only on a write to their register
  property p_osc_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      !(wr && addr == ADDR_OSC) |=> $stable(q.osc);
  endproperty
  a_osc_hold: assert property (p_osc_hold)
    else $error("oscillator bits changed without a write");
  property p_osc_unused;
    @(posedge ref_clk) disable iff (!rst_n)
      (q.osc & ~OSC_WMASK) == 8'h00;
  endproperty
  a_osc_unused: assert property (p_osc_unused)
    else $error("read-only oscillator bits were stored");
  // Trigger bits read back busy while their operation runs
  property p_load_busy_read;
    @(posedge ref_clk) disable iff (!rst_n)
      (rd && addr == ADDR_CTRL && q.op == OP_LOAD)
      |=> (rdata[BIT_LOAD] && !rdata[BIT_SNAP]);
  endproperty
  a_load_busy_read: assert property (p_load_busy_read)
    else $error("load trigger not read back as busy");
  property p_snap_busy_read;
    @(posedge ref_clk) disable iff (!rst_n)
      (rd && addr == ADDR_CTRL && q.op == OP_SNAP)
      |=> (rdata[BIT_SNAP] && !rdata[BIT_LOAD]);
  endproperty
  a_snap_busy_read: assert property (p_snap_busy_read)
    else $error("snapshot trigger not read back as busy");
  property p_idle_read;
    @(posedge ref_clk) disable iff (!rst_n)
      (rd && addr == ADDR_CTRL && q.op == OP_IDLE)
      |=> (rdata[BIT_LOAD] == 1'b0 && rdata[BIT_SNAP] == 1'b0
      && rdata[7:3] == 5'h00);
  endproperty
  a_idle_read: assert property (p_idle_read)
    else $error("trigger bits not clear when idle");
  // A running operation keeps its kind until its last cycle
  property p_busy_refuse;
    @(posedge ref_clk) disable iff (!rst_n)
      (q.op != OP_IDLE && q.cnt != 2'(OP_LAT - 1))
      |=> (q.op == $past(q.op));
  endproperty
  a_busy_refuse: assert property (p_busy_refuse)
    else $error("operation changed before it finished");
  // Alarm flag follows the event and the auto-reset setting
  property p_alarm_set;
    @(posedge ref_clk) disable iff (!rst_n)
      tmr.alarm |=> q.alarm_flag;
  endproperty
  a_alarm_set: assert property (p_alarm_set)
    else $error("alarm event did not raise the flag");
  property p_alarm_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      (q.alarm_flag && !q.auto_rst) |=> q.alarm_flag;
  endproperty
  a_alarm_hold: assert property (p_alarm_hold)
    else $error("alarm flag dropped without auto-reset");
  property p_alarm_auto;
    @(posedge ref_clk) disable iff (!rst_n)
      (!tmr.alarm && q.auto_rst) |=> !q.alarm_flag;
  endproperty
  a_alarm_auto: assert property (p_alarm_auto)
    else $error("auto-reset did not drop the alarm flag");
  // Status bits: an event in the clear cycle still sets its bit
  property p_stat_set;
    @(posedge ref_clk) disable iff (!rst_n)
      tmr.alarm |=> q.stat[IRQ_ALARM];
  endproperty
  a_stat_set: assert property (p_stat_set)
    else $error("alarm status bit not set");
  property p_stat_clear;
    @(posedge ref_clk) disable iff (!rst_n)
      (wr && addr == ADDR_IRQ_CLR && wdata[IRQ_ALARM] && !tmr.alarm)
      |=> !q.stat[IRQ_ALARM];
  endproperty
  a_stat_clear: assert property (p_stat_clear)
    else $error("alarm status bit not cleared");
  property p_stat_read;
    @(posedge ref_clk) disable iff (!rst_n)
      (rd && addr == ADDR_IRQ_STAT) |=> (rdata == {5'h00, $past(q.stat)});
  endproperty
  a_stat_read: assert property (p_stat_read)
    else $error("status register read wrong");
  property p_en_read;
    @(posedge ref_clk) disable iff (!rst_n)
      (rd && addr == ADDR_IRQ_EN) |=> (rdata == {5'h00, $past(q.en)});
  endproperty
  a_en_read: assert property (p_en_read)
    else $error("enable register read wrong");
  // Read data are zero outside the cycle after a read
  property p_rdata_idle;
    @(posedge ref_clk) disable iff (!rst_n)
      !rd |=> (rdata == 8'h00);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside a read");
  property p_unmapped_read;
    @(posedge ref_clk) disable iff (!rst_n)
      (rd && addr > ADDR_OSC && addr != ADDR_IRQ_STAT
       && addr != ADDR_IRQ_EN) |=> (rdata == 8'h00);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped or write-only address read nonzero");
  // Each snapshot byte takes its own write and reads back in place
  for (genvar g = 0; g < 4; g++) begin : g_snap
    property p_snap_write;
      @(posedge ref_clk) disable iff (!rst_n)
        (wr && addr == ADDR_SNAP0 + 8'(g)) |=> (q.snap[g] == $past(wdata));
    endproperty
    a_snap_write: assert property (p_snap_write)
      else $error("snapshot byte write lost");
    property p_snap_read;
      @(posedge ref_clk) disable iff (!rst_n)
        (rd && addr == ADDR_SNAP0 + 8'(g)) |=> (rdata == $past(q.snap[g]));
    endproperty
    a_snap_read: assert property (p_snap_read)
      else $error("snapshot byte read wrong");
  end
  c_load: cover property (@(posedge ref_clk) tmr.load);
  c_snap: cover property (@(posedge ref_clk) ev[IRQ_SNAP]);
  c_alarm: cover property (@(posedge ref_clk) tmr.alarm);
  c_irq: cover property (@(posedge ref_clk) irq);
  c_auto_clear: cover property (@(posedge ref_clk)
    q.alarm_flag && q.auto_rst);
endmodule

// ### common/rtc_osc_pkg.sv
// Package with register map, fields and timing for the RTC control block
package rtc_osc_pkg;
  localparam logic [7:0] ADDR_SNAP0 = 8'h00;
  localparam logic [7:0] ADDR_SNAP3 = 8'h03;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_OSC = 8'h05;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h11;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h12;
  localparam int BIT_ALARM = 2;
  localparam int BIT_LOAD = 1;
  localparam int BIT_SNAP = 0;
  localparam int BIT_GAIN = 7;
  localparam int BIT_MODE = 6;
  localparam int BIT_BIAS = 5;
  localparam int BIT_VALID = 4;
  localparam logic [7:0] OSC_WMASK = 8'hE0;
  localparam logic [7:0] OSC_RESET = 8'h00;
  localparam int IRQ_ALARM = 0;
  localparam int IRQ_LOAD = 1;
  localparam int IRQ_SNAP = 2;
  localparam int OP_LAT = 2;
  typedef enum logic [1:0] {
    OP_IDLE = 2'b00,
    OP_LOAD = 2'b01,
    OP_SNAP = 2'b10
  } op_t;
endpackage

// ### common/timer_if.sv
// Interface between control block and its timer core
`timescale 1ns/1ns
interface timer_if;
  logic load;
  logic [31:0] load_val;
  logic [31:0] count;
  logic alarm;
  modport ctrl (output load, output load_val, input count, input alarm);
  modport core (input load, input load_val, output count, output alarm);
endinterface

// ### rtl/rtc_timer_core.sv
// Free-running 32-bit timer with load and alarm compare
`timescale 1ns/1ns
module rtc_timer_core
  import rtc_osc_pkg::*;
#(
  parameter logic [31:0] ALARM_VAL = 32'h0000_0100
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Timer link
  timer_if.core tmr
);
  typedef struct packed {
    logic [31:0] cnt;
    logic alarm;
  } core_t;
  core_t s_q, s_d;
  always_comb begin
    s_d = s_q;
    s_d.cnt = tmr.load ? tmr.load_val : s_q.cnt + 32'h0000_0001;
    s_d.alarm = (s_q.cnt == ALARM_VAL);
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign tmr.count = s_q.cnt;
  assign tmr.alarm = s_q.alarm;
endmodule

// ### dv/testbench.sv
// Self-checking bench for the RTC control and oscillator registers
`timescale 1ns/1ns
module testbench;
  import rtc_osc_pkg::*;
  logic ref_clk, rst_n, wr, rd, osc_amplitude_ok;
  logic [7:0] addr, wdata, rdata, v;
  logic osc_gain_ctrl_enable, osc_mode_select, osc_bias_double;
  logic alarm_auto_reset, irq;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  typedef struct {logic [7:0] wd; logic amp; logic [7:0] exp;} row_t;
  row_t rows [6] = '{'{8'hFF, 1'b0, 8'hE0}, '{8'h0F, 1'b1, 8'h10},
    '{8'h80, 1'b0, 8'h80}, '{8'h40, 1'b1, 8'h50},
    '{8'h20, 1'b0, 8'h20}, '{8'h00, 1'b0, 8'h00}};
  rtc_ctrl dut (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .osc_amplitude_ok(osc_amplitude_ok),
    .osc_gain_ctrl_enable(osc_gain_ctrl_enable),
    .osc_mode_select(osc_mode_select), .osc_bias_double(osc_bias_double),
    .alarm_auto_reset(alarm_auto_reset), .irq(irq));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Poll a trigger bit until hardware drops it
  task automatic wait_clear(input int b);
    int n;
    n = 0;
    rd_reg(ADDR_CTRL, v);
    check(v[b], 1'b1);
    while (v[b] === 1'b1 && n < 20) begin
      rd_reg(ADDR_CTRL, v);
      n++;
    end
    check(v[b], 1'b0);
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      error_cnt++;
      final_report();
    end
  end
  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    osc_amplitude_ok = 1'b0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd_reg(ADDR_OSC, v);
    check(v, OSC_RESET);
    foreach (rows[i]) begin
      @(posedge ref_clk);
      osc_amplitude_ok <= rows[i].amp;
      wr_reg(ADDR_OSC, rows[i].wd);
      rd_reg(ADDR_OSC, v);
      check(v, rows[i].exp);
      check({5'h00, osc_gain_ctrl_enable, osc_mode_select, osc_bias_double},
        {5'h00, rows[i].exp[7:5]});
    end
    // Alarm while its interrupt is masked, then unmask and clear
    repeat (300) @(posedge ref_clk);
    check(irq, 1'b0);
    rd_reg(ADDR_CTRL, v);
    check(v[BIT_ALARM], 1'b1);
    rd_reg(ADDR_IRQ_STAT, v);
    check(v[IRQ_ALARM], 1'b1);
    wr_reg(ADDR_IRQ_EN, 8'h01);
    @(posedge ref_clk);
    check(irq, 1'b1);
    wr_reg(ADDR_IRQ_CLR, 8'h07);
    @(posedge ref_clk);
    check(irq, 1'b0);
    wr_reg(ADDR_CTRL, 8'h04);
    repeat (3) @(posedge ref_clk);
    check(alarm_auto_reset, 1'b1);
    rd_reg(ADDR_CTRL, v);
    check(v[BIT_ALARM], 1'b0);
    // Load then snapshot, bytes little-endian
    wr_reg(ADDR_IRQ_EN, 8'h02);
    rd_reg(ADDR_IRQ_EN, v);
    check(v, 8'h02);
    for (int i = 0; i < 4; i++) begin
      wr_reg(ADDR_SNAP0 + 8'(i), 8'h00 + 8'(8'h12 * (3 - i)));
    end
    wr_reg(ADDR_CTRL, 8'h06);
    wait_clear(BIT_LOAD);
    check(irq, 1'b1);
    wr_reg(ADDR_IRQ_CLR, 8'h02);
    wr_reg(ADDR_CTRL, 8'h05);
    wait_clear(BIT_SNAP);
    for (int i = 1; i < 4; i++) begin
      rd_reg(ADDR_SNAP0 + 8'(i), v);
      check(v, 8'(8'h12 * (3 - i)));
    end
    rd_reg(ADDR_SNAP0, v);
    check(8'(v < 8'h40), 8'h01);
    rd_reg(ADDR_IRQ_STAT, v);
    check(v[IRQ_SNAP], 1'b1);
    // Unmapped place reads zero and ignores writes
    wr_reg(8'h20, 8'hA5);
    rd_reg(8'h20, v);
    check(v, 8'h00);
    // Mid-run reset returns outputs and registers to zero
    wr_reg(ADDR_OSC, 8'hFF);
    wr_reg(ADDR_IRQ_EN, 8'h07);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    check({4'h0, osc_gain_ctrl_enable, osc_mode_select, osc_bias_double,
      alarm_auto_reset}, 8'h00);
    check(irq, 1'b0);
    rd_reg(ADDR_OSC, v);
    check(v, OSC_RESET);
    rd_reg(ADDR_CTRL, v);
    check(v, 8'h00);
    rd_reg(ADDR_IRQ_STAT, v);
    check(v, 8'h00);
    final_report();
  end
endmodule
